// >>> core/sifb_defines.svh
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 125 MHz clock, APB register access
// Notes:   definitions only
`ifndef SIFB_DEFINES_SVH
`define SIFB_DEFINES_SVH

// Timing
`define SIFB_CLK_HZ        125000000
`define SIFB_TICK_MS       1
`define SIFB_TICK_CYC      ((`SIFB_CLK_HZ / 1000) * `SIFB_TICK_MS)
`define SIFB_FILT_MIN_MS   8'h03
`define SIFB_FILT_MAX_MS   8'hfa

// Register byte offsets
`define SIFB_OFS_CTRL      12'h000
`define SIFB_OFS_FILT      12'h004
`define SIFB_OFS_SIM       12'h008
`define SIFB_OFS_STAT      12'h00c
`define SIFB_OFS_FCLR      12'h010

// Control fields
`define SIFB_CTRL_TYPE_LO  0
`define SIFB_CTRL_RST_EN   2
`define SIFB_CTRL_RST_MON  3
`define SIFB_CTRL_SU_EN    4
`define SIFB_CTRL_TP_EN    5
`define SIFB_CTRL_ERR_EN   6
`define SIFB_CTRL_GRIP_NC  7
`define SIFB_CTRL_GRIP_M2  8
`define SIFB_CTRL_W        9

// Reset values
`define SIFB_CTRL_RST      9'h000
`define SIFB_FILT_RST      8'h03
`define SIFB_SIM_RST       8'h0a

`endif

// >>> core/sifb_pkg.sv
// Purpose: shared types of the safety input block
// Assumes: constants live in sifb_defines.svh
// Notes:   state codes written out
package sifb_pkg;

  typedef enum logic [1:0] {
    SIFB_SENSOR = 2'b00,
    SIFB_MAT    = 2'b01,
    SIFB_SWITCH = 2'b10,
    SIFB_GRIP   = 2'b11
  } sifb_kind_t;

  typedef enum logic [1:0] {
    SIFB_RS_IDLE    = 2'b00,
    SIFB_RS_WAIT_HI = 2'b01,
    SIFB_RS_WAIT_LO = 2'b10
  } sifb_rst_st_t;

  typedef enum logic [1:0] {
    SIFB_SU_ACT  = 2'b00,
    SIFB_SU_REL  = 2'b01,
    SIFB_SU_DONE = 2'b10
  } sifb_su_st_t;

endpackage

// >>> core/sifb_debounce.sv
// Purpose: contact debounce on millisecond ticks
// Assumes: din already synchronised, tick one cycle wide
// Notes:   accepts a change after limit stable ticks, within one tick
`timescale 1ns/1ps
module sifb_debounce (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       din,
  input  wire logic [7:0] limit,
  output logic            dout
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       dout_nxt;
  wire        differ = din != dout;
  wire        done   = tick && (cnt_r + 8'h01 >= limit);

  // Restart count on any bounce back to the held level
  assign cnt_nxt  = !differ ? 8'h00 : (done ? 8'h00 : (tick ? cnt_r + 8'h01 : cnt_r));
  assign dout_nxt = (differ && done) ? din : dout;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= 8'h00;
      dout  <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      dout  <= dout_nxt;
    end
  end

endmodule

// >>> core/sifb_top.sv
// Purpose: input function block evaluation with APB registers
// Assumes: contact pins asynchronous, one 125 MHz clock
// Notes:   output and fault pins come from flip-flops
`timescale 1ns/1ps
`include "sifb_defines.svh"
module sifb_top
  import sifb_pkg::*;
#(
  parameter int MS_CYCLES = `SIFB_TICK_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        contact_input_first,
  input  wire logic        contact_input_second,
  input  wire logic        contact_input_third,
  output logic [1:0]       test_pulse,
  output logic             blk_out,
  output logic             err_out
);

  // Inputs a block kind reads as its own contacts
  function automatic logic [2:0] used_mask(input sifb_kind_t k);
    case (k)
      SIFB_MAT:  used_mask = 3'h3;
      SIFB_GRIP: used_mask = 3'h7;
      default:   used_mask = 3'h1;
    endcase
  endfunction

  logic [`SIFB_CTRL_W-1:0] ctrl_r;
  logic [7:0]              filt_ms_r;
  logic [7:0]              sim_ms_r;
  logic [2:0]              in_s1_r;
  logic [2:0]              in_s2_r;
  logic [2:0]              samp_r;
  logic [16:0]             tick_cnt_r;
  logic                    tick_r;
  logic [1:0]              phase_r;
  logic [2:0]              filt_w;
  logic [7:0]              sim_cnt_r;
  logic                    fault_tp_r;
  logic                    fault_sim_r;
  logic                    eng_prev_r;
  logic                    rst_prev_r;
  sifb_rst_st_t            rs_st_r;
  sifb_rst_st_t            rs_nxt;
  sifb_su_st_t             su_st_r;
  sifb_su_st_t             su_nxt;

  // Control fields
  sifb_kind_t kind;
  assign kind = sifb_kind_t'(ctrl_r[`SIFB_CTRL_TYPE_LO +: 2]);
  wire rst_en  = ctrl_r[`SIFB_CTRL_RST_EN] && (kind != SIFB_GRIP);
  wire rst_mon = ctrl_r[`SIFB_CTRL_RST_MON];
  wire su_en   = ctrl_r[`SIFB_CTRL_SU_EN];
  wire tp_en   = ctrl_r[`SIFB_CTRL_TP_EN];
  wire err_en  = ctrl_r[`SIFB_CTRL_ERR_EN];
  wire grip_nc = ctrl_r[`SIFB_CTRL_GRIP_NC];
  wire grip_m2 = ctrl_r[`SIFB_CTRL_GRIP_M2];
  wire [2:0] used = used_mask(kind);

  // Two-stage synchronisers on the contact pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_s1_r <= 3'h0;
      in_s2_r <= 3'h0;
    end else if (ce) begin
      in_s1_r <= {contact_input_third, contact_input_second, contact_input_first};
      in_s2_r <= in_s1_r;
    end
  end

  // Millisecond tick shared by filters, test pulses and simultaneity
  wire tick_wrap = tick_cnt_r == 17'(MS_CYCLES - 1);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tick_cnt_r <= 17'h00000;
      tick_r     <= 1'b0;
    end else if (ce) begin
      tick_cnt_r <= tick_wrap ? 17'h00000 : tick_cnt_r + 17'h00001;
      tick_r     <= tick_wrap;
    end
  end

  // Test pulse phases: 0 and 2 both high, 1 drops pulse 0, 3 drops pulse 1.
  // Staggered so a short between the two mat lines shows in one phase.
  wire [1:0] tp_nxt = !tp_en ? 2'h3 : {phase_r != 2'h3, phase_r != 2'h1};
  wire       ph_hi  = !phase_r[0];
  wire [2:0] tp_low = (phase_r == 2'h1) ? 3'h5 : ((phase_r == 2'h3) ? 3'h2 : 3'h0);
  // Return seen high while its pulse is low means a foreign source
  wire       tp_mis = tp_en && tick_r && |(in_s2_r & used & tp_low);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase_r    <= 2'h0;
      test_pulse <= 2'h3;
      samp_r     <= 3'h0;
    end else if (ce) begin
      if (tick_r) begin
        phase_r <= phase_r + 2'h1;
      end
      test_pulse <= tp_nxt;
      if (tick_r && ph_hi) begin
        samp_r <= in_s2_r;
      end
    end
  end

  // Pulsed channels take only high-phase samples; the reset line is plain
  wire [2:0] filt_src = (tp_en ? (used & samp_r) : 3'h0) | (~(tp_en ? used : 3'h0) & in_s2_r);

  // One filter per contact; its delay is part of the response time
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      sifb_debounce u_deb (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .tick  (tick_r),
        .din   (filt_src[gi]),
        .limit (filt_ms_r),
        .dout  (filt_w[gi])
      );
    end
  endgenerate

  // Grip position decode; third contact pattern depends on mode
  wire f1   = filt_w[0];
  wire f2   = filt_w[1];
  wire f3   = filt_w[2];
  wire pos2 = f1 && f2 && (!grip_nc || (grip_m2 ? !f3 : f3));
  wire pos1 = !f1 && !f2 && (!grip_nc || f3);

  // Safe condition per block kind
  logic cond;
  assign cond = (kind == SIFB_GRIP)   ? pos2 :
                (kind == SIFB_MAT)    ? f1 && f2 :
                f1;
  // Activation: beam or mat occupied, switch pressed, grip taken
  wire eng = (kind == SIFB_GRIP) ? !pos1 : ((kind == SIFB_SWITCH) ? cond : !cond);

  // Grip contacts disagreeing; counts ms against the limit
  wire sim_mis  = (kind == SIFB_GRIP) && (f1 != f2);
  wire sim_over = sim_mis && tick_r && (sim_cnt_r >= sim_ms_r);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sim_cnt_r <= 8'h00;
    end else if (ce) begin
      sim_cnt_r <= !sim_mis ? 8'h00 : ((tick_r && sim_cnt_r != 8'hff) ? sim_cnt_r + 8'h01
                                                                       : sim_cnt_r);
    end
  end

  // Reset input is the channel after the block's own inputs
  wire rst_in   = (kind == SIFB_MAT) ? f3 : f2;
  wire rst_rise = rst_in && !rst_prev_r;
  wire rst_fall = !rst_in && rst_prev_r;
  wire act_rise = eng && !eng_prev_r;

  // Reset request sequencing
  always_comb begin
    rs_nxt = rs_st_r;
    case (rs_st_r)
      SIFB_RS_IDLE: begin
        if (rst_en && act_rise) begin
          rs_nxt = SIFB_RS_WAIT_HI;
        end
      end
      SIFB_RS_WAIT_HI: begin
        if (!rst_en) begin
          rs_nxt = SIFB_RS_IDLE;
        end else if (rst_rise && !eng) begin
          rs_nxt = rst_mon ? SIFB_RS_WAIT_LO : SIFB_RS_IDLE;
        end
      end
      SIFB_RS_WAIT_LO: begin
        if (!rst_en) begin
          rs_nxt = SIFB_RS_IDLE;
        end else if (act_rise) begin
          rs_nxt = SIFB_RS_WAIT_HI;
        end else if (rst_fall) begin
          rs_nxt = SIFB_RS_IDLE;
        end
      end
      default: rs_nxt = SIFB_RS_IDLE;
    endcase
  end

  // Start-up test, once per power-up; tracks a real edge, not the filters' reset level
  always_comb begin
    su_nxt = su_st_r;
    case (su_st_r)
      SIFB_SU_ACT: begin
        if (act_rise) begin
          su_nxt = SIFB_SU_REL;
        end
      end
      SIFB_SU_REL: begin
        if (!eng) begin
          su_nxt = SIFB_SU_DONE;
        end
      end
      SIFB_SU_DONE: su_nxt = SIFB_SU_DONE;
      default:      su_nxt = SIFB_SU_ACT;
    endcase
  end
  // The sequence runs while disabled too; enabling it late holds the output only if no cycle was seen since power-up
  wire su_ok = (su_st_r == SIFB_SU_DONE) || !su_en;

  // APB decode, one wait state before pready
  wire       acc     = psel && penable && pready;
  wire       wr      = acc && pwrite;
  wire       hit     = paddr == `SIFB_OFS_CTRL || paddr == `SIFB_OFS_FILT ||
                       paddr == `SIFB_OFS_SIM || paddr == `SIFB_OFS_STAT ||
                       paddr == `SIFB_OFS_FCLR;
  wire       pr_nxt  = psel && penable && !pready;
  wire [1:0] fclr    = (wr && paddr == `SIFB_OFS_FCLR) ? pwdata[1:0] : 2'h0;
  wire [7:0] wf      = pwdata[7:0];
  wire [7:0] wf_clip = (wf < `SIFB_FILT_MIN_MS) ? `SIFB_FILT_MIN_MS :
                       ((wf > `SIFB_FILT_MAX_MS) ? `SIFB_FILT_MAX_MS : wf);
  wire [31:0] stat   = {24'h000000, filt_w, su_ok,
                        rs_st_r != SIFB_RS_IDLE, fault_sim_r, fault_tp_r, blk_out};
  wire [31:0] rd_mux = (paddr == `SIFB_OFS_CTRL) ? {23'h000000, ctrl_r} :
                       (paddr == `SIFB_OFS_FILT) ? {24'h000000, filt_ms_r} :
                       (paddr == `SIFB_OFS_SIM)  ? {24'h000000, sim_ms_r} :
                       (paddr == `SIFB_OFS_STAT) ? stat : 32'h00000000;

  // Faults stick until cleared; a new fault beats the clear
  wire fault_any = fault_tp_r || fault_sim_r;
  wire out_nxt   = cond && (rs_st_r == SIFB_RS_IDLE) && su_ok &&
                   !fault_any;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      ctrl_r  <= `SIFB_CTRL_RST;
      filt_ms_r <= `SIFB_FILT_RST;
      sim_ms_r  <= `SIFB_SIM_RST;
    end else if (ce) begin
      pready  <= pr_nxt;
      pslverr <= pr_nxt && !hit;
      prdata  <= pr_nxt ? rd_mux : 32'h00000000;
      if (wr && paddr == `SIFB_OFS_CTRL) begin
        ctrl_r <= pwdata[`SIFB_CTRL_W-1:0];
      end
      if (wr && paddr == `SIFB_OFS_FILT) begin
        filt_ms_r <= wf_clip;
      end
      if (wr && paddr == `SIFB_OFS_SIM) begin
        sim_ms_r <= wf;
      end
    end
  end

  // Block state and pins
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fault_tp_r  <= 1'b0;
      fault_sim_r <= 1'b0;
      eng_prev_r  <= 1'b1; // Filters reset low; no false activation edge
      rst_prev_r  <= 1'b0;
      rs_st_r     <= SIFB_RS_IDLE;
      su_st_r     <= SIFB_SU_ACT;
      blk_out     <= 1'b0;
      err_out     <= 1'b0;
    end else if (ce) begin
      fault_tp_r  <= tp_mis || (fault_tp_r && !fclr[0]);
      fault_sim_r <= sim_over || (fault_sim_r && !fclr[1]);
      eng_prev_r  <= eng;
      rst_prev_r  <= rst_in;
      rs_st_r     <= rs_nxt;
      su_st_r     <= su_nxt;
      blk_out     <= out_nxt;
      err_out     <= err_en && fault_any;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_mon_rise;
    ce && rs_st_r == SIFB_RS_WAIT_HI && rst_en && rst_mon && rst_rise && !eng;
  endsequence
  sequence s_mon_fall;
    ce && rs_st_r == SIFB_RS_WAIT_LO && rst_en && !act_rise && rst_fall;
  endsequence

  a_sensor_blocked: assert property (ce && kind == SIFB_SENSOR && !f1 |=> !blk_out)
    else $error("sensor output high with beam blocked");
  a_reset_pend_low: assert property (ce && rs_st_r != SIFB_RS_IDLE |=> !blk_out)
    else $error("output high while reset pending");
  a_manual_rise: assert property (ce && rs_st_r == SIFB_RS_WAIT_HI && rst_en && !rst_mon
                                  && rst_rise && !eng |=> rs_st_r == SIFB_RS_IDLE)
    else $error("manual reset edge not accepted");
  a_monitored_seq: assert property (s_mon_rise |=> rs_st_r == SIFB_RS_WAIT_LO)
    else $error("monitored reset accepted on rise alone");
  a_monitored_end: assert property (s_mon_fall |=> rs_st_r == SIFB_RS_IDLE)
    else $error("monitored reset fall not accepted");
  a_tp_fault_set: assert property (tp_mis && ce |=> fault_tp_r ##1 (fault_tp_r || !ce
                                   || $past(fclr[0])))
    else $error("test pulse mismatch not flagged");
  a_startup_hold: assert property (ce && !su_ok |=> !blk_out)
    else $error("output high before start-up test");
  a_filter_range: assert property (filt_ms_r >= 8'h03 && filt_ms_r <= 8'hfa)
    else $error("filter time out of range");
  a_err_out_fault: assert property (ce && err_en && fault_any |=> err_out)
    else $error("fault output not raised");
  a_mat_pressed: assert property (ce && kind == SIFB_MAT && !(f1 && f2) |=> !blk_out)
    else $error("mat output high while pressed");
  a_grip_middle: assert property (ce && kind == SIFB_GRIP && !pos2 |=> !blk_out)
    else $error("grip output high outside middle");
  a_sim_overrun: assert property (ce && sim_over |=> fault_sim_r ##1 !blk_out || !ce)
    else $error("simultaneity overrun not a fault");
  a_fault_low: assert property (ce && fault_any |=> !blk_out)
    else $error("output high during fault");

endmodule

// >>> testbench/sifb_field_model.sv
// Purpose: field contacts seen by the safety input block
// Assumes: open contact reads low, closed contact returns its pulse
// Notes:   short_hi ties the second line to supply to fake a short
`timescale 1ns/1ps
module sifb_field_model (
  input  wire logic [1:0] test_pulse,
  input  wire logic [2:0] closed,
  input  wire logic       short_hi,
  output logic            contact_input_first,
  output logic            contact_input_second,
  output logic            contact_input_third
);
  // Four-wire contacts, first and second lines each fed by their own pulse output
  assign contact_input_first  = closed[0] & test_pulse[0];
  assign contact_input_second = short_hi | (closed[1] & test_pulse[1]);
  // Third line shares pulse 0; reset pin sits right after used inputs
  assign contact_input_third  = closed[2] & test_pulse[0];
endmodule

// >>> testbench/sifb_tb_top.sv
// Purpose: self-checking bench of the safety input block
// Assumes: MS_CYCLES shortened to 20 so a millisecond is 20 cycles
// Notes:   a second reset arms the start-up test at the end
`timescale 1ns/1ps
module safety_input_function_blocks_tb_top;
  localparam int MS = 20;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic        blk_out, err_out, short_hi, c1, c2, c3, e, s0, s1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rs, f;
  logic [1:0]  test_pulse;
  logic [2:0]  closed;
  int          err_total, total_checks;
  localparam logic [11:0] GT [0:10] = '{
    12'h043, 12'h0c3, 12'h0c3, 12'h0c3, 12'h0c3, 12'h1c3, 12'h1c3, 12'h1c3,
    12'h1c3, 12'h043, 12'h043};
  localparam logic [2:0] GC [0:10] = '{3'b011, 3'b100, 3'b111, 3'b000, 3'b110,
    3'b100, 3'b011, 3'b000, 3'b111, 3'b000, 3'b011};

  sifb_top #(.MS_CYCLES(MS)) dut (.clk(clk), .nrst(nrst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_input_first(c1), .contact_input_second(c2), .contact_input_third(c3),
    .test_pulse(test_pulse), .blk_out(blk_out), .err_out(err_out));
  sifb_field_model fld (.test_pulse(test_pulse), .closed(closed), .short_hi(short_hi),
    .contact_input_first(c1), .contact_input_second(c2), .contact_input_third(c3));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Filter writes are clamped into the legal span
  function automatic logic [31:0] clampf(input logic [31:0] v);
    return (v < 32'h3) ? 32'h3 : (v > 32'hfa) ? 32'hfa : v;
  endfunction
  // Grip middle position from the three contact levels
  function automatic logic grip_exp(input logic [11:0] c, input logic [2:0] v);
    return v[0] & v[1] & (!c[7] | (c[8] ? !v[2] : v[2]));
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== ex) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle(input int ms);
    repeat (ms * MS) @(posedge clk);
  endtask
  // Wait for blk_out (which 0) or err_out (which 1) to reach a level
  task automatic wait_o(input logic which, input logic ex, input string nm);
    int n;
    n = 0;
    while (((which ? err_out : blk_out) !== ex) && n < 14 * MS) begin
      @(posedge clk);
      n++;
    end
    chk(nm, ex, which ? err_out : blk_out);
  endtask
  // Let the filter settle first so an unchanged level is a real check
  task automatic step(input logic [2:0] c, input logic ex, input string nm);
    closed <= c;
    settle(4);
    wait_o(1'b0, ex, nm);
  endtask
  // Activation, clearance, then a reset pulse on the next input
  task automatic run_rst(input logic mon);
    apb(1'b1, 12'h000, mon ? 32'hc : 32'h4);
    step(3'b001, 1'b1, "rst_pre");
    // Each level is held past the longest filter plus one tick of jitter
    closed <= 3'b000;
    settle(10);
    closed <= 3'b001;
    settle(10);
    chk("rst_held", 32'h0, blk_out);
    closed <= 3'b011;
    if (mon) begin
      settle(10);
      chk("mon_rise", 32'h0, blk_out);
      closed <= 3'b001;
    end
    @(posedge clk);
    wait_o(1'b0, 1'b1, "rst_ok");
    closed <= 3'b001;
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (80000) @(posedge clk);
    err_total++;
    test_done();
  end

  // Main sequence
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, short_hi} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    closed = 3'b000;
    rs = 32'hc1621ba0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values, clamping and an unmapped place
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl_rst", 32'h0, q);
    apb(1'b0, 12'h004, 32'h0);
    chk("filt_rst", 32'h3, q);
    apb(1'b0, 12'h008, 32'h0);
    chk("sim_rst", 32'ha, q);
    apb(1'b0, 12'h00c, 32'h0);
    chk("su_done", 32'h1, {31'h0, q[4]});
    apb(1'b0, 12'h014, 32'h0);
    chk("unmap_err", 32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      f = (i == 0) ? 32'h1 : (i == 1) ? 32'hff : {24'h0, rs[7:0]};
      apb(1'b1, 12'h004, f);
      apb(1'b0, 12'h004, 32'h0);
      chk("filt_clamp", clampf(f), q);
    end
    // Sensor: random filter, output must hold for the filter span less one tick
    rs = xs(rs);
    f = 32'h3 + (rs % 6);
    apb(1'b1, 12'h004, f);
    apb(1'b1, 12'h000, 32'h0);
    step(3'b001, 1'b1, "sens_clear");
    closed <= 3'b000;
    repeat ((f - 1) * MS) @(posedge clk);
    chk("sens_filt", 32'h1, blk_out);
    wait_o(1'b0, 1'b0, "sens_block");
    run_rst(1'b0);
    run_rst(1'b1);
    // Switch
    apb(1'b1, 12'h000, 32'h2);
    step(3'b000, 1'b0, "sw_off");
    step(3'b001, 1'b1, "sw_on");
    // Mat with test pulses and fault output
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h000, 32'h61);
    step(3'b011, 1'b1, "mat_clear");
    {s0, s1} = 2'b00;
    repeat (5 * MS) begin
      @(posedge clk);
      s0 = s0 | !test_pulse[0];
      s1 = s1 | !test_pulse[1];
    end
    chk("pulses", 32'h3, {30'h0, s1, s0});
    step(3'b010, 1'b0, "mat_press");
    step(3'b011, 1'b1, "mat_free");
    short_hi <= 1'b1;
    @(posedge clk);
    wait_o(1'b1, 1'b1, "tp_fault");
    chk("tp_hold", 32'h0, blk_out);
    short_hi <= 1'b0;
    settle(8);
    chk("tp_sticky", 32'h0, blk_out);
    apb(1'b1, 12'h010, 32'h3);
    wait_o(1'b1, 1'b0, "tp_clr");
    wait_o(1'b0, 1'b1, "mat_back");
    // Grip positions in both input types and both modes
    for (int i = 0; i < 11; i++) begin
      if (i == 0 || GT[i] != GT[i - 1])
        apb(1'b1, 12'h000, {20'h0, GT[i]});
      step(GC[i], grip_exp(GT[i], GC[i]), "grip_pos");
    end
    // Grip simultaneity overrun
    apb(1'b1, 12'h008, 32'h3);
    closed <= 3'b001;
    @(posedge clk);
    wait_o(1'b1, 1'b1, "sim_fault");
    chk("sim_hold", 32'h0, blk_out);
    closed <= 3'b000;
    settle(6);
    apb(1'b1, 12'h010, 32'h2);
    wait_o(1'b1, 1'b0, "sim_clr");
    // Second power-up, sensor with the start-up test armed
    closed <= 3'b001;
    nrst <= 1'b0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b1, 12'h000, 32'h10);
    step(3'b001, 1'b0, "su_wait");
    step(3'b000, 1'b0, "su_act");
    step(3'b001, 1'b1, "su_rel");
    test_done();
  end
endmodule
